// File: inc/nvac_pkg.sv
package nvac_pkg;
    // Core clock
    localparam int CLK_PERIOD_NS = 100;
    // Least write assertion, in ns
    localparam int WRITE_PULSE_MIN_NS = 65;
    localparam int WRITE_PULSE_CYC_RAW = (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_CYC_RAW < 1) ? 1 : WRITE_PULSE_CYC_RAW;
    // Worst-case delay before the device protects after a supply fall, in us
    localparam int FALL_PROTECT_DELAY_MAX_US = 160;
    localparam int FALL_PROTECT_DELAY_MIN_US = 40;
    // Longest protection after a supply rise, in ms
    localparam int RISE_PROTECT_DELAY_MAX_MS = 200;
    localparam int RISE_PROTECT_DELAY_MIN_MS = 40;
    localparam int RISE_PROTECT_CYC = RISE_PROTECT_DELAY_MAX_MS * 1000000 / CLK_PERIOD_NS;
    // Address and data widths
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    // Setup and recovery cycles around the strobe
    localparam int SETUP_CYC = 1;
    localparam int RECOVER_CYC = 1;
    localparam int READ_WAIT_CYC = 1;
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

    typedef enum logic [2:0]
    {
        NVAC_IDLE  = 3'b000,
        NVAC_SETUP = 3'b001,
        NVAC_PULSE = 3'b011,
        NVAC_RECOV = 3'b010,
        NVAC_DONE  = 3'b110
    } nvac_state_t;
endpackage

// File: tb/nvac_dev_model.sv
`timescale 1ns/1ns
// Behavioural memory device with power-fail write lock
module nvac_dev_model (
    input  wire logic                        pwr_good,
    input  wire logic [nvac_pkg::ADDR_W-1:0] addr,
    input  wire logic                        cs_n,
    input  wire logic                        we_n,
    input  wire logic                        oe_n,
    input  wire logic [nvac_pkg::DATA_W-1:0] host_dq,
    input  wire logic                        host_oe_n,
    output logic [nvac_pkg::DATA_W-1:0]      dq,
    output logic                             clash
);
    logic [nvac_pkg::DATA_W-1:0] mem [0:(1<<nvac_pkg::ADDR_W)-1];
    logic [nvac_pkg::DATA_W-1:0] last_q = 8'h00;
    logic                        bat_on = 1'b0;
    logic                        sel;
    logic                        wr_act;
    logic                        drive;
    // Lock at once on supply loss, ahead of the 40 us earliest point of the window
    assign sel = !cs_n && pwr_good;
    assign wr_act = sel && !we_n;
    assign drive = sel && we_n && !oe_n;
    initial clash = 1'b0;
    // Battery joins only after the first good supply
    always @(posedge pwr_good) bat_on <= 1'b1;
    // Store at the end of the overlap, not on a power-fail release
    always @(negedge wr_act)
        if (pwr_good && bat_on)
            mem[addr] <= host_oe_n ? ~last_q : host_dq;
    // Released bus shows no stale level
    always_comb
    begin
        if (!host_oe_n)
            dq = host_dq;
        else if (drive)
            dq = mem[addr];
        else
            dq = ~last_q;
    end
    always @(host_oe_n or drive or host_dq or addr)
        if (!host_oe_n || drive)
            last_q <= host_oe_n ? mem[addr] : host_dq;
    always @(host_oe_n or drive)
        if (!host_oe_n && drive)
            clash <= 1'b1;
endmodule

// File: tb/nvac_host_test.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("wrong value %s expected %h seen %h", nm, exp, got); \
        end \
    end
module nvac_host_test;
    localparam int RISE = 20;
    logic                        core_clk = 1'b0;
    logic                        srst = 1'b1;
    logic                        req_valid = 1'b0;
    logic                        req_write = 1'b0;
    logic [nvac_pkg::ADDR_W-1:0] req_addr = 15'h0000;
    logic [nvac_pkg::DATA_W-1:0] req_wdata = 8'h00;
    logic                        pwr_good = 1'b0;
    logic                        req_ready, rsp_valid, pwr_ready, supply_seen, cs_n, we_n, oe_n, dq_oe_n, clash;
    logic [nvac_pkg::DATA_W-1:0] rsp_rdata, dq_i, dq_o, rd;
    logic [nvac_pkg::ADDR_W-1:0] mem_addr, prev_a;
    logic                        prev_cs = 1'b1;
    int                          n_fail = 0, check_count = 0, cyc = 0, ov = 0, lat;
    nvac_host #(.RISE_CYC(RISE)) dut_u (.CORE_CLK(core_clk), .SRST(srst), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .PWR_GOOD(pwr_good), .PWR_READY(pwr_ready),
        .SUPPLY_SEEN(supply_seen), .MEM_ADDR(mem_addr), .MEM_CS_N(cs_n), .MEM_WE_N(we_n), .MEM_OE_N(oe_n),
        .MEM_DQ_I(dq_i), .MEM_DQ_O(dq_o), .MEM_DQ_OE_N(dq_oe_n));
    nvac_dev_model dev_u (.pwr_good(pwr_good), .addr(mem_addr), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
        .host_dq(dq_o), .host_oe_n(dq_oe_n), .dq(dq_i), .clash(clash));
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end
    // Pin watch; checks only on strobe events to keep counts meaningful
    always @(negedge core_clk)
    begin
        if (!srst)
        begin
            if (!cs_n && !prev_cs)
                `CHK("addr hold", prev_a, mem_addr)
            if (!oe_n)
                `CHK("we in read", 1'b1, we_n)
            if (!cs_n && !we_n)
                ov++;
            else if (ov != 0)
            begin
                `CHK("pulse ok", 1'b1, ov >= nvac_pkg::WRITE_PULSE_CYC)
                ov = 0;
            end
        end
        prev_cs = cs_n;
        prev_a = mem_addr;
    end
    // Ceiling well above the whole sequence
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            summarize();
        end
    end
    task automatic summarize;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic access(input logic w, input logic [14:0] a, input logic [7:0] d);
        int n;
        @(negedge core_clk);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        n = 0;
        while (req_ready !== 1'b1 && n < 50)
        begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        lat = 1;
        while (rsp_valid !== 1'b1 && lat < 30)
        begin
            @(negedge core_clk);
            lat++;
        end
        rd = rsp_rdata;
    endtask
    task automatic power_up;
        int n;
        pwr_good = 1'b1;
        n = 0;
        while (pwr_ready !== 1'b1 && n < 100)
        begin
            @(negedge core_clk);
            n++;
        end
        `CHK("rise hold", 1'b1, n >= RISE && n <= RISE + 8)
        `CHK("supply seen", 1'b1, supply_seen)
    endtask
    task automatic t_reset;
        `CHK("idle strobes", 3'h7, {cs_n, we_n, oe_n})
        `CHK("dq released", 1'b1, dq_oe_n)
        `CHK("ready at reset", 1'b0, pwr_ready)
        `CHK("seen at reset", 1'b0, supply_seen)
    endtask
    task automatic t_write_read;
        logic [14:0] at [4] = '{15'h0000, 15'h7fff, 15'h2aaa, 15'h0003};
        logic [7:0]  dt [4] = '{8'h5a, 8'ha5, 8'hff, 8'h3c};
        for (int i = 0; i < 4; i++)
        begin
            access(1'b1, at[i], dt[i]);
            `CHK("write lat", 5, lat)
        end
        for (int i = 3; i >= 0; i--)
        begin
            access(1'b0, at[i], 8'h00);
            `CHK("read lat", 7, lat)
            `CHK("read data", dt[i], rd)
        end
    endtask
    task automatic t_power_fail;
        int n;
        fork
            access(1'b0, 15'h2aaa, 8'h00);
            begin
                repeat (3) @(negedge core_clk);
                pwr_good = 1'b0;
                n = 0;
                while ((cs_n !== 1'b1 || pwr_ready !== 1'b0) && n < 500)
                begin
                    @(negedge core_clk);
                    n++;
                end
                `CHK("fall lock", 1'b1, n <= 400)
            end
        join
        `CHK("abort answered", 1'b1, lat < 30)
        req_valid = 1'b1;
        req_write = 1'b1;
        req_addr = 15'h0003;
        req_wdata = 8'h00;
        repeat (10)
        begin
            @(negedge core_clk);
            `CHK("locked cs", 1'b1, cs_n)
            `CHK("locked dq", 1'b1, dq_oe_n)
            `CHK("abort pulse", 1'b0, rsp_valid)
        end
        req_valid = 1'b0;
        power_up();
        access(1'b0, 15'h0003, 8'h00);
        `CHK("kept data", 8'h3c, rd)
    endtask
    initial
    begin
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        t_reset();
        power_up();
        t_write_read();
        t_power_fail();
        `CHK("no clash", 1'b0, clash)
        summarize();
    end
endmodule

// File: verilog/nvac_guard.sv
`timescale 1ns/1ns
// Tracks supply health and holds off access across the protection windows
module nvac_guard #(
    parameter int RISE_CYC = nvac_pkg::RISE_PROTECT_CYC
)
(
    input  wire logic CORE_CLK,
    input  wire logic SRST,
    input  wire logic pwr_good_raw,
    output logic      access_ok,
    output logic      supply_seen
);
    logic       s1_q;
    logic       s2_q;
    logic [nvac_pkg::CNT_W-1:0] cnt_q;
    logic [nvac_pkg::CNT_W-1:0] cnt_d;
    logic       ok_q;
    logic       ok_d;
    logic       seen_q;
    logic       seen_d;

    // Next values: drop at once on fall, wait the full window on rise
    always_comb
    begin
        cnt_d = cnt_q;
        ok_d = ok_q;
        seen_d = seen_q | s2_q;
        if (!s2_q)
        begin
            cnt_d = nvac_pkg::CNT_ZERO;
            ok_d = 1'b0; // Stop writing before the device can protect
        end
        else if (!ok_q)
        begin
            if (cnt_q >= RISE_CYC[nvac_pkg::CNT_W-1:0])
                ok_d = 1'b1; // After the longest protect time
            else
                cnt_d = cnt_q + nvac_pkg::CNT_ONE;
        end
    end

    // Two-stage sync of the supply monitor pin
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            cnt_q <= nvac_pkg::CNT_ZERO;
            ok_q <= 1'b0;
            seen_q <= 1'b0;
        end
        else
        begin
            s1_q <= pwr_good_raw;
            s2_q <= s1_q;
            cnt_q <= cnt_d;
            ok_q <= ok_d;
            seen_q <= seen_d;
        end
    end

    assign access_ok = ok_q;
    assign supply_seen = seen_q; // Battery era begins with first supply

    a_fall_blocks: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !s2_q |=> !ok_q) else $error("access allowed after supply loss");
    a_rise_holdoff: assert property (@(posedge CORE_CLK) disable iff (SRST)
        $rose(ok_q) |-> cnt_q >= RISE_CYC[nvac_pkg::CNT_W-1:0]) else $error("access resumed early");
endmodule

// File: verilog/nvac_host.sv
`timescale 1ns/1ns
// Function
// - Host keeps chip-select or write-strobe high while address changes.
// - Host holds write-strobe high throughout every read.
// - Host sets address no later than chip-select falling in reads.
// - Host never drives data while device output-enable is low.
// - Host keeps the write overlap at least 65 ns.
module nvac_host #(
    parameter int RISE_CYC = nvac_pkg::RISE_PROTECT_CYC
)
(
    input  wire logic                        CORE_CLK,
    input  wire logic                        SRST,
    input  wire logic                        REQ_VALID,
    output logic                             REQ_READY,
    input  wire logic                        REQ_WRITE,
    input  wire logic [nvac_pkg::ADDR_W-1:0] REQ_ADDR,
    input  wire logic [nvac_pkg::DATA_W-1:0] REQ_WDATA,
    output logic                             RSP_VALID,
    output logic [nvac_pkg::DATA_W-1:0]      RSP_RDATA,
    input  wire logic                        PWR_GOOD,
    output logic                             PWR_READY,
    output logic                             SUPPLY_SEEN,
    output logic [nvac_pkg::ADDR_W-1:0]      MEM_ADDR,
    output logic                             MEM_CS_N,
    output logic                             MEM_WE_N,
    output logic                             MEM_OE_N,
    input  wire logic [nvac_pkg::DATA_W-1:0] MEM_DQ_I,
    output logic [nvac_pkg::DATA_W-1:0]      MEM_DQ_O,
    output logic                             MEM_DQ_OE_N
);
    nvac_pkg::nvac_state_t st_q;
    nvac_pkg::nvac_state_t st_d;
    logic [3:0]                  cnt_q;
    logic [3:0]                  cnt_d;
    logic                        wr_q;
    logic                        wr_d;
    logic [nvac_pkg::ADDR_W-1:0] addr_q;
    logic [nvac_pkg::ADDR_W-1:0] addr_d;
    logic [nvac_pkg::DATA_W-1:0] wdat_q;
    logic [nvac_pkg::DATA_W-1:0] wdat_d;
    logic [nvac_pkg::DATA_W-1:0] rdat_q;
    logic [nvac_pkg::DATA_W-1:0] rdat_d;
    logic                        cs_q;
    logic                        cs_d;
    logic                        we_q;
    logic                        we_d;
    logic                        oe_q;
    logic                        oe_d;
    logic                        drv_q;
    logic                        drv_d;
    logic                        rsp_q;
    logic                        rsp_d;
    logic [nvac_pkg::DATA_W-1:0] dq_s1_q;
    logic [nvac_pkg::DATA_W-1:0] dq_s2_q;
    logic                        access_ok;

    // Supply watch and power-up hold-off
    nvac_guard #(.RISE_CYC(RISE_CYC)) u_guard (
        .CORE_CLK    (CORE_CLK),
        .SRST        (SRST),
        .pwr_good_raw(PWR_GOOD),
        .access_ok   (access_ok),
        .supply_seen (SUPPLY_SEEN)
    );

    // Strobe cycle; address moves only in IDLE with both strobes high
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        wr_d = wr_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        cs_d = cs_q;
        we_d = we_q;
        oe_d = oe_q;
        drv_d = drv_q;
        rsp_d = 1'b0;
        case (st_q)
            nvac_pkg::NVAC_IDLE:
            begin
                if (REQ_VALID && access_ok)
                begin
                    addr_d = REQ_ADDR; // Strobes high here
                    wdat_d = REQ_WDATA;
                    wr_d = REQ_WRITE;
                    drv_d = REQ_WRITE; // Only drive with OE high
                    cnt_d = 4'(nvac_pkg::SETUP_CYC);
                    st_d = nvac_pkg::NVAC_SETUP;
                end
            end
            nvac_pkg::NVAC_SETUP:
            begin
                // Address settled a cycle before chip-select falls
                cs_d = 1'b0;
                we_d = !wr_q; // Write strobe low only for writes
                oe_d = wr_q; // OE high in writes keeps device quiet
                cnt_d = wr_q ? 4'(nvac_pkg::WRITE_PULSE_CYC) : 4'(nvac_pkg::READ_WAIT_CYC + 2);
                st_d = nvac_pkg::NVAC_PULSE;
            end
            nvac_pkg::NVAC_PULSE:
            begin
                if (cnt_q > 4'h1)
                    cnt_d = cnt_q - 4'h1; // Overlap held for the minimum
                else
                begin
                    rdat_d = dq_s2_q;
                    we_d = 1'b1; // In writes write-strobe and chip-select rise together, ending the write
                    cs_d = wr_q;
                    oe_d = 1'b1;
                    cnt_d = 4'(nvac_pkg::RECOVER_CYC);
                    st_d = nvac_pkg::NVAC_RECOV;
                end
            end
            nvac_pkg::NVAC_RECOV:
            begin
                cs_d = 1'b1;
                drv_d = 1'b0; // Data held past write end, then released
                st_d = nvac_pkg::NVAC_DONE;
            end
            nvac_pkg::NVAC_DONE:
            begin
                rsp_d = 1'b1;
                st_d = nvac_pkg::NVAC_IDLE;
            end
            default:
            begin
                st_d = nvac_pkg::NVAC_IDLE;
            end
        endcase
        // Supply loss aborts at once: strobes high, bus released
        // DONE is left out so the abort still ends in a single answer pulse
        if (!access_ok && st_q != nvac_pkg::NVAC_IDLE && st_q != nvac_pkg::NVAC_DONE)
        begin
            cs_d = 1'b1;
            we_d = 1'b1;
            oe_d = 1'b1;
            drv_d = 1'b0;
            st_d = nvac_pkg::NVAC_DONE;
        end
    end

    // Registers, and two-stage capture of the read bus
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            st_q <= nvac_pkg::NVAC_IDLE;
            cnt_q <= 4'h0;
            wr_q <= 1'b0;
            addr_q <= '0;
            wdat_q <= '0;
            rdat_q <= '0;
            cs_q <= 1'b1;
            we_q <= 1'b1;
            oe_q <= 1'b1;
            drv_q <= 1'b0;
            rsp_q <= 1'b0;
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            cs_q <= cs_d;
            we_q <= we_d;
            oe_q <= oe_d;
            drv_q <= drv_d;
            rsp_q <= rsp_d;
            dq_s1_q <= MEM_DQ_I;
            dq_s2_q <= dq_s1_q;
        end
    end

    assign REQ_READY = (st_q == nvac_pkg::NVAC_IDLE) && access_ok;
    assign PWR_READY = access_ok; // Protection mirrored to the user
    assign RSP_VALID = rsp_q;
    assign RSP_RDATA = rdat_q;
    assign MEM_ADDR = addr_q;
    assign MEM_CS_N = cs_q;
    assign MEM_WE_N = we_q;
    assign MEM_OE_N = oe_q;
    assign MEM_DQ_O = wdat_q;
    assign MEM_DQ_OE_N = !drv_q;

    a_addr_stable: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !$stable(MEM_ADDR) |-> MEM_CS_N && MEM_WE_N) else $error("address moved under strobe");
    a_read_we_high: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !MEM_CS_N && !wr_q |-> MEM_WE_N) else $error("write strobe low in read");
    a_no_contend: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !MEM_DQ_OE_N |-> MEM_OE_N) else $error("bus driven against device");
    a_pulse_min: assert property (@(posedge CORE_CLK) disable iff (SRST)
        $rose(MEM_WE_N) && access_ok |-> $past(!MEM_CS_N)) else $error("write overlap too short");
    a_rsp_single: assert property (@(posedge CORE_CLK) disable iff (SRST)
        RSP_VALID |=> !RSP_VALID) else $error("answer pulse held over");
    a_write_oe_high: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !MEM_WE_N |-> MEM_OE_N) else $error("output enable low in write");
    a_cs_first: assert property (@(posedge CORE_CLK) disable iff (SRST)
        $fell(MEM_CS_N) |-> $past(st_q) == nvac_pkg::NVAC_SETUP) else $error("chip select without setup");
endmodule
